/* hw/cdsn_clock_network.v */
// Clock dividers, select, center mux and synthesizer output logic
`timescale 1ns/100ps
`default_nettype none
`include "cdsn_map.vh"

// Operation
// - Primary divider feeds one select input only
// - Edge divider ratios 2, 3.5, 4, 5
// - Edge phase fixed by reset release
// - Divider reset forces outputs low asynchronously
// - Output resumes after synchronous reset release
// - Edge divider sources, output to bottom mid
// - Six synthesizer outputs, independent dividers
// - Output divider values 1 through 128
// - Lock flag follows lock gained and lost
// - Phase shift static or driven by fabric
// - Four domains, sixteen clocks each
// - Center mux: 64 feeds, 16 trunks
// - Select unit switches between two clocks
module cdsn_clock_network #(
  parameter N_SYNTH = 6,
  parameter N_TRUNK = 16,
  parameter N_DOMAIN = 4,
  parameter N_FEED = 64,
  parameter N_MID = 61
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  output wire irq,
  // Synthesizer loop and phase controls
  input wire synth_lock_raw,
  input wire [2:0] phase_dir_select,
  input wire phase_dir,
  input wire phase_rotate,
  input wire phase_load,
  output reg synth_lock_q,
  output wire [N_SYNTH-1:0] synth_out,
  // Edge divider sources and output
  input wire edge_pin_clk,
  input wire quarter_delay_slave,
  input wire edge_route_clk,
  output reg edge_clk_net_q,
  // Select unit second inputs
  input wire [1:0] dcs_alt_clk,
  output wire [1:0] dynamic_clk_select,
  // Mid mux feeds and domain clocks
  input wire [N_MID-1:0] mid_clk,
  output wire [N_TRUNK-1:0] center_clk_mux,
  output wire [N_DOMAIN*N_TRUNK-1:0] domain_clk
);

  integer i;
  integer j;

  function [7:0] pdiv_ratio;
    input [2:0] code;
    begin
      pdiv_ratio = 8'h01 << code;
    end
  endfunction

  function [7:0] sdiv_clamp;
    input [7:0] v;
    begin
      if (v == 8'h00) begin
        sdiv_clamp = 8'h01;
      end else if (v > `CDSN_SDIV_MAX) begin
        sdiv_clamp = `CDSN_SDIV_MAX;
      end else begin
        sdiv_clamp = v;
      end
    end
  endfunction

  function [2:0] edge_last;
    input [1:0] mode;
    begin
      case (mode)
        `CDSN_EMODE_DIV2: edge_last = 3'h1;
        `CDSN_EMODE_DIV3P5: edge_last = 3'h6;
        `CDSN_EMODE_DIV4: edge_last = 3'h3;
        default: edge_last = 3'h4;
      endcase
    end
  endfunction

  function edge_level;
    input [1:0] mode;
    input [2:0] cnt;
    begin
      case (mode)
        `CDSN_EMODE_DIV2: edge_level = (cnt == 3'h0);
        // Two periods of four and three edges average 3.5
        `CDSN_EMODE_DIV3P5: edge_level = (cnt[1] == 1'b0) && (cnt != 3'h6);
        `CDSN_EMODE_DIV4: edge_level = (cnt < 3'h2);
        default: edge_level = (cnt < 3'h3);
      endcase
    end
  endfunction

  // Register file
  reg [31:0] ctrl_q;
  reg [31:0] sel_q;
  reg [`CDSN_IRQ_WIDTH-1:0] isr_q;
  reg [`CDSN_IRQ_WIDTH-1:0] imr_q;
  reg [14:0] sdiv_q [0:N_SYNTH-1];
  reg [5:0] trunk_q [0:N_TRUNK-1];

  wire sdiv_hit;
  wire trunk_hit;
  wire [2:0] sdiv_idx;
  wire [3:0] trunk_idx;
  assign sdiv_idx = reg_addr[4:2];
  assign trunk_idx = reg_addr[5:2];
  assign sdiv_hit = (reg_addr[7:5] == `CDSN_SDIV_PAGE) &&
    (sdiv_idx < N_SYNTH) && (reg_addr[1:0] == 2'b00);
  assign trunk_hit = (reg_addr[7:6] == `CDSN_TRUNK_PAGE) &&
    (reg_addr[1:0] == 2'b00);

  // Lock and phase event tracking
  reg rot_prev_q;
  reg load_prev_q;
  wire rot_pulse;
  wire load_pulse;
  wire [`CDSN_IRQ_WIDTH-1:0] events;
  assign rot_pulse = phase_rotate & ~rot_prev_q;
  assign load_pulse = phase_load & ~load_prev_q;
  assign events = {rot_pulse | load_pulse,
    synth_lock_q & ~synth_lock_raw,
    ~synth_lock_q & synth_lock_raw};

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      synth_lock_q <= 1'b0;
      rot_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      synth_lock_q <= synth_lock_raw;
      rot_prev_q <= phase_rotate;
      load_prev_q <= phase_load;
    end
  end

  wire rd_isr;
  assign rd_isr = reg_rd && (reg_addr == `CDSN_REG_ISR);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `CDSN_CTRL_RESET;
      sel_q <= `CDSN_SEL_RESET;
      isr_q <= {`CDSN_IRQ_WIDTH{1'b0}};
      imr_q <= {`CDSN_IRQ_WIDTH{1'b0}};
      for (i = 0; i < N_SYNTH; i = i + 1) begin
        sdiv_q[i] <= `CDSN_SDIV_RESET;
      end
      for (i = 0; i < N_TRUNK; i = i + 1) begin
        trunk_q[i] <= 6'h00;
      end
    end else begin
      // A new event wins over the read that clears
      isr_q <= (rd_isr ? {`CDSN_IRQ_WIDTH{1'b0}} : isr_q) | events;
      if (reg_wr) begin
        case (reg_addr)
          `CDSN_REG_CTRL: ctrl_q <= reg_wdata;
          `CDSN_REG_SEL: sel_q <= reg_wdata;
          `CDSN_REG_IMR: imr_q <= reg_wdata[`CDSN_IRQ_WIDTH-1:0];
          default: begin
            if (sdiv_hit) begin
              sdiv_q[sdiv_idx] <= reg_wdata[14:0];
            end
            if (trunk_hit) begin
              trunk_q[trunk_idx] <= reg_wdata[5:0];
            end
          end
        endcase
      end
    end
  end

  assign irq = |(isr_q & imr_q);

  // Primary dividers feeding the select units
  wire [1:0] pdiv_clk;

  cdsn_divider #(.W(8)) u_pdiv0 (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .div_rst(ctrl_q[`CDSN_CTRL_PRST0_BIT]),
    .ratio(pdiv_ratio(ctrl_q[`CDSN_CTRL_PDIV0_LSB +: 3])),
    .hold(1'b0),
    .skip(1'b0),
    .load(1'b0),
    .load_val(8'h00),
    .clk_o(pdiv_clk[0])
  );

  cdsn_divider #(.W(8)) u_pdiv1 (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .div_rst(ctrl_q[`CDSN_CTRL_PRST1_BIT]),
    .ratio(pdiv_ratio(ctrl_q[`CDSN_CTRL_PDIV1_LSB +: 3])),
    .hold(1'b0),
    .skip(1'b0),
    .load(1'b0),
    .load_val(8'h00),
    .clk_o(pdiv_clk[1])
  );

  // Select units: input 0 divider, input 1 external only
  reg [1:0] dcs_act_q;
  reg [1:0] pdiv_seen_q;
  reg [1:0] alt_seen_q;
  wire [1:0] dcs_req;
  wire [1:0] dcs_gl;
  assign dcs_req = sel_q[`CDSN_SEL_DCS_LSB +: 2];
  assign dcs_gl = sel_q[`CDSN_SEL_GLITCHLESS_LSB +: 2];

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dcs_act_q <= 2'b00;
      pdiv_seen_q <= 2'b00;
      alt_seen_q <= 2'b00;
    end else begin
      pdiv_seen_q <= pdiv_clk;
      alt_seen_q <= dcs_alt_clk;
      for (j = 0; j < 2; j = j + 1) begin
        // Glitchless switching waits for both inputs low
        if (!dcs_gl[j] ||
            (!pdiv_seen_q[j] && !alt_seen_q[j])) begin
          dcs_act_q[j] <= dcs_req[j];
        end
      end
    end
  end

  assign dynamic_clk_select[0] = dcs_act_q[0] ? dcs_alt_clk[0] :
    pdiv_clk[0];
  assign dynamic_clk_select[1] = dcs_act_q[1] ? dcs_alt_clk[1] :
    pdiv_clk[1];

  // Synthesizer output dividers, held low while unlocked
  genvar g;
  generate
    for (g = 0; g < N_SYNTH; g = g + 1) begin : g_sdiv
      wire pick;
      assign pick = ({29'h0, phase_dir_select} == g);
      cdsn_divider #(.W(8)) u_sdiv (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .div_rst(~synth_lock_q),
        .ratio(sdiv_clamp(sdiv_q[g][7:0])),
        .hold(rot_pulse & pick & ~phase_dir),
        .skip(rot_pulse & pick & phase_dir),
        .load(load_pulse & pick),
        .load_val({1'b0, sdiv_q[g][14:8]}),
        .clk_o(synth_out[g])
      );
    end
  endgenerate

  // Edge divider on the selected source's rising edges
  reg esrc_val;
  reg esrc_prev_q;
  reg erst1_q;
  reg erun_q;
  reg [2:0] ecnt_q;
  wire [3:0] esrc;
  wire [1:0] emode;
  wire earst_n;
  assign esrc = ctrl_q[`CDSN_CTRL_ESRC_LSB +: 4];
  assign emode = ctrl_q[`CDSN_CTRL_EMODE_LSB +: 2];
  assign earst_n = reset_n & ~ctrl_q[`CDSN_CTRL_ERST_BIT];

  always @* begin
    if (esrc < N_SYNTH) begin
      esrc_val = synth_out[esrc[2:0]];
    end else if (esrc == `CDSN_ESRC_PIN) begin
      esrc_val = edge_pin_clk;
    end else if (esrc == `CDSN_ESRC_PIN_DLY) begin
      esrc_val = quarter_delay_slave;
    end else begin
      esrc_val = edge_route_clk;
    end
  end

  always @(posedge ref_clk or negedge earst_n) begin
    if (!earst_n) begin
      erst1_q <= 1'b0;
      erun_q <= 1'b0;
      esrc_prev_q <= 1'b0;
      ecnt_q <= 3'h0;
      edge_clk_net_q <= 1'b0;
    end else begin
      erst1_q <= 1'b1;
      erun_q <= erst1_q;
      esrc_prev_q <= esrc_val;
      // Count restarts at zero on release, fixing the phase
      if (erun_q && esrc_val && !esrc_prev_q) begin
        edge_clk_net_q <= edge_level(emode, ecnt_q);
        if (ecnt_q >= edge_last(emode)) begin
          ecnt_q <= 3'h0;
        end else begin
          ecnt_q <= ecnt_q + 3'h1;
        end
      end
    end
  end

  // Center mux: 64 feeds onto 16 trunks
  wire [N_FEED-1:0] feeds;
  assign feeds = {mid_clk, edge_clk_net_q, dynamic_clk_select};

  generate
    for (g = 0; g < N_TRUNK; g = g + 1) begin : g_trunk
      assign center_clk_mux[g] = feeds[trunk_q[g]];
    end
  endgenerate

  // Domain gates: each domain carries all sixteen trunks
  generate
    for (g = 0; g < N_DOMAIN; g = g + 1) begin : g_dom
      assign domain_clk[g*N_TRUNK +: N_TRUNK] = center_clk_mux &
        {N_TRUNK{sel_q[`CDSN_SEL_GATE_LSB + g]}};
    end
  endgenerate

  // Read port, data one cycle after the strobe
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CDSN_REG_CTRL: reg_rdata_q <= ctrl_q;
        `CDSN_REG_SEL: reg_rdata_q <= sel_q;
        `CDSN_REG_STAT: reg_rdata_q <= {29'h0, dcs_act_q, synth_lock_q};
        `CDSN_REG_ISR: reg_rdata_q <= {29'h0, isr_q};
        `CDSN_REG_IMR: reg_rdata_q <= {29'h0, imr_q};
        default: begin
          if (sdiv_hit) begin
            reg_rdata_q <= {17'h0, sdiv_q[sdiv_idx]};
          end else if (trunk_hit) begin
            reg_rdata_q <= {26'h0, trunk_q[trunk_idx]};
          end else begin
            reg_rdata_q <= 32'h0000_0000;
          end
        end
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

endmodule // cdsn_clock_network

`default_nettype wire

/* common/cdsn_map.vh */
// Register offsets, fields and reset values of the clock network block
`ifndef CDSN_MAP_VH
`define CDSN_MAP_VH

// Register byte offsets
`define CDSN_REG_CTRL 8'h00
`define CDSN_REG_SEL 8'h04
`define CDSN_REG_STAT 8'h08
`define CDSN_REG_ISR 8'h0C
`define CDSN_REG_IMR 8'h10
`define CDSN_SDIV_PAGE 3'h1
`define CDSN_TRUNK_PAGE 2'h1

// Control fields
`define CDSN_CTRL_PDIV0_LSB 0
`define CDSN_CTRL_PDIV1_LSB 4
`define CDSN_CTRL_EMODE_LSB 8
`define CDSN_CTRL_ESRC_LSB 12
`define CDSN_CTRL_PRST0_BIT 16
`define CDSN_CTRL_PRST1_BIT 17
`define CDSN_CTRL_ERST_BIT 18
`define CDSN_CTRL_RESET 32'h0000_0000

// Select fields
`define CDSN_SEL_DCS_LSB 0
`define CDSN_SEL_GLITCHLESS_LSB 2
`define CDSN_SEL_GATE_LSB 8
`define CDSN_SEL_RESET 32'h0000_0F00

// Interrupt status bits
`define CDSN_IRQ_LOCK_GAINED 0
`define CDSN_IRQ_LOCK_LOST 1
`define CDSN_IRQ_PHASE_DONE 2
`define CDSN_IRQ_WIDTH 3

// Synthesizer output divider entry
`define CDSN_SDIV_RESET 15'h0001
`define CDSN_SDIV_MAX 8'h80

// Edge divider modes and sources
`define CDSN_EMODE_DIV2 2'h0
`define CDSN_EMODE_DIV3P5 2'h1
`define CDSN_EMODE_DIV4 2'h2
`define CDSN_EMODE_DIV5 2'h3
`define CDSN_ESRC_PIN 4'h6
`define CDSN_ESRC_PIN_DLY 4'h7

`endif

/* hw/cdsn_divider.v */
// Integer clock divider with its own reset synchroniser
`timescale 1ns/100ps
`default_nettype none

module cdsn_divider #(
  parameter W = 8
) (
  // Clock and resets
  input wire ref_clk,
  input wire reset_n,
  input wire div_rst,
  // Ratio and phase steering
  input wire [W-1:0] ratio,
  input wire hold,
  input wire skip,
  input wire load,
  input wire [W-1:0] load_val,
  // Divided clock
  output wire clk_o
);

  wire arst_n;
  reg sync1_q;
  reg run_q;
  reg out_q;
  reg [W-1:0] cnt_q;
  reg [W:0] sum;
  reg [W-1:0] nxt;
  wire [W:0] half;

  // Either reset forces the output low at once
  assign arst_n = reset_n & ~div_rst;
  assign half = ({1'b0, ratio} + {{W{1'b0}}, 1'b1}) >> 1;

  always @* begin
    sum = {1'b0, cnt_q} + (skip ? {{(W-1){1'b0}}, 2'b10} :
      {{W{1'b0}}, 1'b1});
    if (sum >= {1'b0, ratio}) begin
      sum = sum - {1'b0, ratio};
    end
    if (sum >= {1'b0, ratio}) begin
      sum = {(W+1){1'b0}};
    end
    nxt = sum[W-1:0];
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b0;
      run_q <= 1'b0;
      out_q <= 1'b0;
      cnt_q <= {W{1'b0}};
    end else begin
      // Release is retimed so the first edge is a whole cycle
      sync1_q <= 1'b1;
      run_q <= sync1_q;
      if (run_q) begin
        if (load) begin
          cnt_q <= (load_val < ratio) ? load_val : {W{1'b0}};
          out_q <= 1'b1;
        end else if (!hold) begin
          cnt_q <= nxt;
          out_q <= ({1'b0, nxt} < half);
        end
      end
    end
  end

  // Ratio one passes the clock through, gated by the run flag
  assign clk_o = (ratio == {{(W-1){1'b0}}, 1'b1}) ?
    (ref_clk & run_q) : out_q;

endmodule // cdsn_divider

`default_nettype wire

/* sim/cdsn_clock_network_asserts.sv */
// Port checker of the clock network block
`timescale 1ns/100ps
`default_nettype none
`include "cdsn_map.vh"
module cdsn_clock_network_asserts #(
  parameter N_SYNTH = 6,
  parameter N_TRUNK = 16,
  parameter N_DOMAIN = 4,
  parameter N_MID = 61
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_q,
  input wire logic irq,
  // Synthesizer and edge divider
  input wire logic synth_lock_raw,
  input wire logic phase_rotate,
  input wire logic synth_lock_q,
  input wire logic [N_SYNTH-1:0] synth_out,
  input wire logic edge_clk_net_q,
  // Center mux and domains
  input wire logic [N_MID-1:0] mid_clk,
  input wire logic [N_TRUNK-1:0] center_clk_mux,
  input wire logic [N_DOMAIN*N_TRUNK-1:0] domain_clk
);
  // Shadows of the written control bits
  logic [31:0] ctrl_q;
  logic gate0_q;
  logic [5:0] feed0_q;
  logic mask2_q;
  default clocking cb @(posedge ref_clk);
  endclocking
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `CDSN_CTRL_RESET;
      gate0_q <= 1'b1;
      feed0_q <= 6'h00;
      mask2_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `CDSN_REG_CTRL)
        ctrl_q <= reg_wdata;
      if (reg_addr == `CDSN_REG_SEL)
        gate0_q <= reg_wdata[8];
      if (reg_addr == 8'h40)
        feed0_q <= reg_wdata[5:0];
      if (reg_addr == `CDSN_REG_IMR)
        mask2_q <= reg_wdata[2];
    end
  end
  a_reset_outs_low: assert property (!reset_n |->
    !synth_lock_q && !edge_clk_net_q && synth_out == '0)
    else $error("outputs not low in reset");
  a_lock_follows: assert property (disable iff (!reset_n)
    $past(reset_n) |-> synth_lock_q == $past(synth_lock_raw))
    else $error("lock flag does not follow the loop");
  a_phase_irq: assert property (disable iff (!reset_n)
    $rose(phase_rotate) && mask2_q |-> ##[1:3] irq)
    else $error("phase step raised no interrupt");
  a_edge_rst_low: assert property (disable iff (!reset_n)
    ctrl_q[`CDSN_CTRL_ERST_BIT] |-> ##2 !edge_clk_net_q)
    else $error("edge output not low in divider reset");
  a_sync_release: assert property (disable iff (!reset_n)
    $fell(ctrl_q[`CDSN_CTRL_ERST_BIT]) |-> !edge_clk_net_q [*2])
    else $error("edge output before synchronised release");
  a_domain_on: assert property (disable iff (!reset_n)
    gate0_q |-> domain_clk[N_TRUNK-1:0] == center_clk_mux)
    else $error("domain zero does not carry the trunks");
  a_trunk_feed: assert property (disable iff (!reset_n)
    feed0_q >= 6'h03 |-> center_clk_mux[0] == mid_clk[feed0_q - 6'h03])
    else $error("trunk zero not fed from chosen mid feed");
  a_ctrl_readback: assert property (disable iff (!reset_n)
    reg_rd && reg_addr == `CDSN_REG_CTRL |=>
    (reg_rdata_q & 32'h0007_F377) == (ctrl_q & 32'h0007_F377))
    else $error("control read back differs");
endmodule // cdsn_clock_network_asserts
bind cdsn_clock_network cdsn_clock_network_asserts #(.N_SYNTH(N_SYNTH),
  .N_TRUNK(N_TRUNK), .N_DOMAIN(N_DOMAIN), .N_MID(N_MID))
  cdsn_clock_network_asserts_inst (.ref_clk(ref_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq(irq),
  .synth_lock_raw(synth_lock_raw), .phase_rotate(phase_rotate),
  .synth_lock_q(synth_lock_q), .synth_out(synth_out),
  .edge_clk_net_q(edge_clk_net_q), .mid_clk(mid_clk),
  .center_clk_mux(center_clk_mux), .domain_clk(domain_clk));
`default_nettype wire

/* sim/cdsn_fabric_model.sv */
// Fabric-side model: lock synchroniser and phase step driver
`timescale 1ns/100ps
`default_nettype none
module cdsn_fabric_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bench commands
  input wire logic step_req,
  input wire logic [1:0] step_kind,
  input wire logic step_slow,
  output logic step_busy,
  // Block side
  input wire logic synth_lock_q,
  output logic lock_sync,
  output logic [2:0] phase_dir_select,
  output logic phase_dir,
  output logic phase_rotate,
  output logic phase_load
);
  logic sync_q;
  logic load_q;
  logic [2:0] cnt_q;
  assign step_busy = cnt_q != 3'h0;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {sync_q, lock_sync, load_q, cnt_q} <= 6'h00;
      {phase_dir_select, phase_dir, phase_rotate, phase_load} <= 6'h00;
    end else begin
      // Lock is foreign to the output clocks, so two stages
      sync_q <= synth_lock_q;
      lock_sync <= sync_q;
      if (step_req && !step_busy) begin
        // Steering settles before the pulse and holds through it
        phase_dir_select <= {1'b0, step_kind};
        phase_dir <= step_kind[0];
        load_q <= step_kind[1];
        cnt_q <= step_slow ? 3'h7 : 3'h5;
      end else if (step_busy)
        cnt_q <= cnt_q - 3'h1;
      phase_rotate <= !load_q && cnt_q >= 3'h2 && cnt_q <= 3'h4;
      phase_load <= load_q && cnt_q >= 3'h2 && cnt_q <= 3'h4;
    end
  end
endmodule // cdsn_fabric_model
`default_nettype wire

/* sim/tb_cdsn_clock_network.sv */
// Self-checking bench of the clock network block
`timescale 1ns/100ps
`default_nettype none
`include "cdsn_map.vh"
module tb_cdsn_clock_network;
  logic ref_clk, reset_n, reg_wr, reg_rd, lock_raw, lock_sync, irq;
  logic lock_q, edge_q, pin_clk, dly_clk, route_clk, rd_seen, busy;
  logic step_req, step_slow, ph_dir, ph_rot, ph_load;
  logic [1:0] step_kind, alt_clk, dcs_out;
  logic [2:0] ph_sel;
  logic [5:0] synth_out;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, r1, r2, d;
  logic [60:0] mid_clk;
  logic [15:0] trunk;
  logic [63:0] domain;
  logic [6:0] probe;
  logic [31:0] exp_q[$];
  int miscompares, n_checks, n, i, idx, seed;
  int rat[6] = '{2, 3, 128, 200, 5, 4};
  int ediv[4] = '{8, 14, 16, 20};
  assign probe = {edge_q, synth_out};
  cdsn_clock_network cdsn_clock_network_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .irq(irq), .synth_lock_raw(lock_raw), .phase_dir_select(ph_sel),
    .phase_dir(ph_dir), .phase_rotate(ph_rot), .phase_load(ph_load),
    .synth_lock_q(lock_q), .synth_out(synth_out),
    .edge_pin_clk(pin_clk), .quarter_delay_slave(dly_clk),
    .edge_route_clk(route_clk), .edge_clk_net_q(edge_q),
    .dcs_alt_clk(alt_clk), .dynamic_clk_select(dcs_out),
    .mid_clk(mid_clk), .center_clk_mux(trunk), .domain_clk(domain));
  cdsn_fabric_model cdsn_fabric_model_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .step_req(step_req), .step_kind(step_kind),
    .step_slow(step_slow), .step_busy(busy), .synth_lock_q(lock_q),
    .lock_sync(lock_sync), .phase_dir_select(ph_sel),
    .phase_dir(ph_dir), .phase_rotate(ph_rot), .phase_load(ph_load));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Delayed pin follows the pin one cycle late
  always @(posedge ref_clk) begin
    r1 = $random(seed);
    r2 = $random(seed);
    pin_clk <= ~pin_clk;
    dly_clk <= pin_clk;
    route_clk <= r1[31];
    alt_clk <= r1[30:29];
    mid_clk <= {r1[28:0], r2};
    if (rd_seen)
      check("read data", exp_q.pop_front(), reg_rdata_q);
    rd_seen <= reg_rd;
  end
  task automatic check(input string nm, input logic [31:0] e, got);
    n_checks++;
    if (got !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic give_up;
    miscompares++;
    $display("wait ran out");
    print_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  // Cycles spanned by np periods of probe bit b
  task automatic meas(input int b, input int np, output int p);
    int k, r;
    logic prev;
    r = 0;
    p = 0;
    prev = probe[b];
    for (k = 0; k < 700 && r <= np; k++) begin
      @(posedge ref_clk);
      #1;
      if (r > 0)
        p++;
      if (!prev && probe[b])
        r++;
      prev = probe[b];
    end
    if (r <= np)
      give_up();
  endtask
  task automatic wait_lock(input logic v);
    int k;
    for (k = 0; k < 20 && lock_sync !== v; k++)
      @(posedge ref_clk);
    if (lock_sync !== v)
      give_up();
    #1;
  endtask
  task automatic step(input logic [1:0] kind, input logic slow);
    int k;
    @(posedge ref_clk);
    step_req <= 1'b1;
    step_kind <= kind;
    step_slow <= slow;
    @(posedge ref_clk);
    step_req <= 1'b0;
    #1;
    for (k = 0; k < 20 && busy !== 1'b0; k++)
      @(posedge ref_clk);
    if (busy !== 1'b0)
      give_up();
    #1;
  endtask
  initial begin
    seed = 32'h0000_92ec;
    // Reset by NBA so every process sees its falling edge
    reset_n <= 1'b0;
    {reg_wr, reg_rd, lock_raw, pin_clk, rd_seen} = 5'h00;
    {dly_clk, route_clk, alt_clk, step_req, step_kind, step_slow} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    mid_clk = '0;
    miscompares = 0;
    n_checks = 0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`CDSN_REG_CTRL, `CDSN_CTRL_RESET);
    rd(`CDSN_REG_SEL, `CDSN_SEL_RESET);
    rd(8'hFC, 32'h0000_0000);
    $display("test reset values done");
    wr(`CDSN_REG_IMR, 32'h0000_0007);
    lock_raw <= 1'b1;
    wait_lock(1'b1);
    check("irq", 32'h1, {31'h0, irq});
    rd(`CDSN_REG_ISR, 32'h0000_0001);
    #1;
    check("irq", 32'h0, {31'h0, irq});
    rd(`CDSN_REG_STAT, 32'h0000_0001);
    for (i = 0; i < 6; i++)
      wr(8'h20 + 8'(4 * i), 32'(rat[i]));
    for (i = 0; i < 6; i++) begin
      meas(i, 2, n);
      check("synth period", 32'(2 * (rat[i] > 128 ? 128 : rat[i])),
        32'(n));
    end
    $display("test lock and synth dividers done");
    for (i = 0; i < 3; i++) begin
      step(i[1:0], i[0]);
      check("irq", 32'h1, {31'h0, irq});
      rd(`CDSN_REG_ISR, 32'h0000_0004);
    end
    wr(`CDSN_REG_IMR, 32'h0000_0003);
    step(2'h1, 1'b0);
    check("irq", 32'h0, {31'h0, irq});
    rd(`CDSN_REG_ISR, 32'h0000_0004);
    lock_raw <= 1'b0;
    wait_lock(1'b0);
    check("irq", 32'h1, {31'h0, irq});
    rd(`CDSN_REG_ISR, 32'h0000_0002);
    $display("test phase steps and lock loss done");
    for (i = 0; i < 8; i++) begin
      wr(`CDSN_REG_CTRL, 32'(i * 17));
      rd(`CDSN_REG_CTRL, 32'(i * 17));
    end
    for (i = 0; i < 8; i++) begin
      d = 32'(((6 + i / 4) << 12) | ((i % 4) << 8));
      wr(`CDSN_REG_CTRL, d | 32'h0004_0000);
      wr(`CDSN_REG_CTRL, d);
      meas(6, 2, n);
      check("edge period", 32'(ediv[i % 4]), 32'(n));
    end
    $display("test dividers done");
    idx = 3 + ($unsigned($random(seed)) % 61);
    wr(8'h40, 32'(idx));
    #1;
    check("trunk", {31'h0, mid_clk[idx - 3]}, {31'h0, trunk[0]});
    wr(`CDSN_REG_SEL, 32'h0000_0102);
    // Select unit follows the register one edge later
    @(posedge ref_clk);
    #1;
    check("gated off", 32'h0, {16'h0, domain[63:48]});
    check("select alt", {31'h0, alt_clk[1]}, {31'h0, dcs_out[1]});
    // Bypassed divider shows the high clock phase here
    check("select div", 32'h1, {31'h0, dcs_out[0]});
    rd(`CDSN_REG_STAT, 32'h0000_0004);
    $display("test trunks and select done");
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("outputs in reset", 32'h0, {25'h0, probe});
    @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`CDSN_REG_SEL, `CDSN_SEL_RESET);
    repeat (2) @(posedge ref_clk);
    $display("test second reset done");
    print_verdict();
  end
endmodule // tb_cdsn_clock_network
`default_nettype wire
